// ---- src/rgb_pkg.sv ----
// Shared constants and types of the RGB PWM dimming core.
// Functional notes
// - Each sink output carries a 12-bit resolution PWM near 32.6 kHz.
// - Each sink channel has its own 8-bit colour level.
// - Channels 3m to 3m+2 share the intensity level of module m.
// - Each module intensity level gives 256 distinct steps on the linear curve.
// - Intensity resets to full scale, where it scales the colour by one.
// - One global bit picks a logarithmic or a linear intensity curve.
// - The logarithmic curve acts on intensity only, never on colour.
// - LEDs count as idle only after staying dark for the 30 ms deglitch.
// - The serial interface resets within 3 us after enable falls.
// - Two address pins set the low bus address bits, four devices per bus.
// - Final duty is the colour level times the module intensity.
// - Duty is 9-bit PWM plus 3 dither bits; a dither bit off gives 9 bits.
// - Modules 0 and 3 fix the rising edge, module 1 the centre, module 2 the falling edge.
// - Power save only with auto-sleep on and LEDs dark; any access wakes.
package rgb_pkg;

  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int PWM_HZ = 29_000;
  localparam int PWM_STEPS = 512;
  localparam int PWM_TICK_DIV = CLK_HZ / (PWM_HZ * PWM_STEPS);
  localparam int IDLE_DEGLITCH_MS = 30;
  localparam int IDLE_DEGLITCH_CYC = (CLK_HZ / 1000) * IDLE_DEGLITCH_MS;

  // Geometry
  localparam int NUM_CH = 12;
  localparam int NUM_MOD = 4;
  localparam int CH_PER_MOD = 3;

  // Bus address: upper five bits, value arbitrary
  localparam logic [4:0] BUS_ADDR_HI = 5'h14;

  // Register map
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h01;
  localparam logic [7:0] REG_INT_BASE = 8'h02;
  localparam logic [7:0] REG_INT_LAST = 8'h05;
  localparam logic [7:0] REG_COLOR_BASE = 8'h06;
  localparam logic [7:0] REG_COLOR_LAST = 8'h11;

  // Reset values
  localparam logic [7:0] CFG_RESET = 8'h07;
  localparam logic [7:0] INTENSITY_RESET = 8'hFF;
  localparam logic [7:0] COLOR_RESET = 8'h00;

  // Global configuration register layout
  typedef struct packed {
    logic [4:0] rsvd;
    logic auto_sleep;
    logic dither_en;
    logic log_scale;
  } rgb_cfg_type;

  // PWM timebase shared by all channels
  typedef struct packed {
    logic step;
    logic wrap;
    logic [8:0] cnt;
    logic [2:0] frame;
  } rgb_tb_type;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_REG, ST_RACK,
    ST_WDATA, ST_WACK, ST_RDATA, ST_MACK
  } rgb_i2c_state_type;

endpackage

// ---- src/rgb_pwm_channel.sv ----
// One sink channel: duty product, dither and phase-placed PWM.
module rgb_pwm_channel (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  // Timebase and levels
  input rgb_pkg::rgb_tb_type tb_i,
  input wire logic [7:0] color_i,
  input wire logic [7:0] intensity_i,
  input wire logic dither_en_i,
  input wire logic [1:0] phase_i,
  // Output
  output logic pwm_o,
  output logic lit_o
);

  logic [16:0] prod;
  logic [11:0] duty;
  logic [11:0] duty_q;
  logic dith_q;
  logic [9:0] width;
  logic [9:0] lo;
  logic [9:0] c;
  logic on;

  // Full-scale intensity scales by exactly one
  assign prod = 17'(color_i) * (17'(intensity_i) + 17'h00001);
  assign duty = dither_en_i ? prod[15:4] : {prod[15:7], 3'h0};

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      duty_q <= 12'h000;
      dith_q <= 1'b0;
    end else if (clr_i) begin
      duty_q <= 12'h000;
      dith_q <= 1'b0;
    end else if (tb_i.wrap) begin
      duty_q <= duty;
      dith_q <= (tb_i.frame < duty[2:0]);
    end
  end

  assign width = {1'b0, duty_q[11:3]} + {9'h000, dith_q};
  assign lo = 10'h100 - {1'b0, width[9:1]};
  assign c = {1'b0, tb_i.cnt};

  always_comb begin
    case (phase_i)
      2'h0: on = c < width;
      2'h1: on = (c >= lo) && (c < lo + width);
      default: on = c >= 10'h200 - width;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwm_o <= 1'b0;
    end else if (clr_i) begin
      pwm_o <= 1'b0;
    end else if (tb_i.step) begin
      pwm_o <= on && (width != 10'h000);
    end
  end

  assign lit_o = duty_q != 12'h000;

endmodule

// ---- src/rgb_pwm_core.sv ----
// Top of the RGB dimming core: serial register slave, timebase, sleep.
module rgb_pwm_core #(
  parameter int IDLE_DEGLITCH_CYC = rgb_pkg::IDLE_DEGLITCH_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Enable and address pins
  input wire logic en_i,
  input wire logic [1:0] bus_select_pins_i,
  // Serial bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // LED sinks and status
  output logic [11:0] sink_channel_n_o,
  output logic power_save_o
);

  localparam int IW = $clog2(IDLE_DEGLITCH_CYC + 1);

  // Pin synchronisers: {en, sel[1:0], scl, sda}
  logic [4:0] s1_q;
  logic [4:0] s2_q;
  logic [1:0] bus_prev_q;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= 5'h03;
      s2_q <= 5'h03;
      bus_prev_q <= 2'h3;
    end else begin
      s1_q <= {en_i, bus_select_pins_i, scl_i, sda_i};
      s2_q <= s1_q;
      bus_prev_q <= s2_q[1:0];
    end
  end

  logic en;
  logic scl;
  logic sda;
  logic clr;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [6:0] my_addr;

  assign en = s2_q[4];
  assign clr = ~en;
  assign scl = s2_q[1];
  assign sda = s2_q[0];
  assign scl_rise = scl & ~bus_prev_q[1];
  assign scl_fall = ~scl & bus_prev_q[1];
  assign start_det = scl & bus_prev_q[1] & bus_prev_q[0] & ~sda;
  assign stop_det = scl & bus_prev_q[1] & ~bus_prev_q[0] & sda;
  assign my_addr = {rgb_pkg::BUS_ADDR_HI, s2_q[3:2]};

  // Register file
  rgb_pkg::rgb_cfg_type cfg_q;
  logic [7:0] color_q [rgb_pkg::NUM_CH];
  logic [7:0] int_q [rgb_pkg::NUM_MOD];
  logic [7:0] ptr_q;
  logic [7:0] shift_q;
  logic [3:0] bitcnt_q;
  logic rw_q;
  logic nack_q;
  rgb_pkg::rgb_i2c_state_type state_q;
  logic wr_stb;
  logic [7:0] rd_now;
  logic [7:0] rd_next;

  function automatic logic [7:0] rd_mux(input logic [7:0] a,
                                        input rgb_pkg::rgb_cfg_type cf,
                                        input logic ps);
    logic [7:0] idx;
    idx = 8'h00;
    rd_mux = 8'h00;
    if (a == rgb_pkg::REG_CFG) begin
      rd_mux = cf;
    end else if (a == rgb_pkg::REG_STATUS) begin
      rd_mux = {7'h00, ps};
    end else if (a >= rgb_pkg::REG_INT_BASE && a <= rgb_pkg::REG_INT_LAST) begin
      idx = a - rgb_pkg::REG_INT_BASE;
      rd_mux = int_q[idx[1:0]];
    end else if (a >= rgb_pkg::REG_COLOR_BASE &&
                 a <= rgb_pkg::REG_COLOR_LAST) begin
      idx = a - rgb_pkg::REG_COLOR_BASE;
      rd_mux = color_q[idx[3:0]];
    end
  endfunction

  // Process form so the mux follows register contents read inside it
  always_comb begin
    rd_now = rd_mux(ptr_q, cfg_q, power_save_o);
    rd_next = rd_mux(ptr_q + 8'h01, cfg_q, power_save_o);
  end
  assign wr_stb = scl_fall && state_q == rgb_pkg::ST_WDATA && bitcnt_q == 4'h8;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    logic [7:0] widx;
    widx = 8'h00;
    if (rst_i) begin
      cfg_q <= rgb_pkg::CFG_RESET;
      for (int i = 0; i < rgb_pkg::NUM_CH; i++) color_q[i] <= rgb_pkg::COLOR_RESET;
      for (int i = 0; i < rgb_pkg::NUM_MOD; i++) int_q[i] <= rgb_pkg::INTENSITY_RESET;
    end else if (clr) begin
      cfg_q <= rgb_pkg::CFG_RESET;
      for (int i = 0; i < rgb_pkg::NUM_CH; i++) color_q[i] <= rgb_pkg::COLOR_RESET;
      for (int i = 0; i < rgb_pkg::NUM_MOD; i++) int_q[i] <= rgb_pkg::INTENSITY_RESET;
    end else if (wr_stb) begin
      if (ptr_q == rgb_pkg::REG_CFG) begin
        cfg_q <= {5'h00, shift_q[2:0]};
      end else if (ptr_q >= rgb_pkg::REG_INT_BASE &&
                   ptr_q <= rgb_pkg::REG_INT_LAST) begin
        widx = ptr_q - rgb_pkg::REG_INT_BASE;
        int_q[widx[1:0]] <= shift_q;
      end else if (ptr_q >= rgb_pkg::REG_COLOR_BASE &&
                   ptr_q <= rgb_pkg::REG_COLOR_LAST) begin
        widx = ptr_q - rgb_pkg::REG_COLOR_BASE;
        color_q[widx[3:0]] <= shift_q;
      end
    end
  end

  // Serial slave: bits taken on SCL rise, SDA driven after SCL fall
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= rgb_pkg::ST_IDLE;
      ptr_q <= 8'h00;
      shift_q <= 8'h00;
      bitcnt_q <= 4'h0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (clr || stop_det) begin
      state_q <= rgb_pkg::ST_IDLE;
      sda_oe_o <= 1'b0;
    end else if (start_det) begin
      state_q <= rgb_pkg::ST_ADDR;
      bitcnt_q <= 4'h0;
      sda_oe_o <= 1'b0;
    end else if (scl_rise) begin
      case (state_q)
        rgb_pkg::ST_ADDR, rgb_pkg::ST_REG, rgb_pkg::ST_WDATA: begin
          shift_q <= {shift_q[6:0], sda};
          bitcnt_q <= bitcnt_q + 4'h1;
        end
        rgb_pkg::ST_RDATA: bitcnt_q <= bitcnt_q + 4'h1;
        rgb_pkg::ST_MACK: nack_q <= sda;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (state_q)
        rgb_pkg::ST_ADDR: begin
          if (bitcnt_q == 4'h8) begin
            if (shift_q[7:1] == my_addr) begin
              rw_q <= shift_q[0];
              sda_oe_o <= 1'b1;
              state_q <= rgb_pkg::ST_AACK;
            end else begin
              state_q <= rgb_pkg::ST_IDLE;
            end
          end
        end
        rgb_pkg::ST_AACK: begin
          bitcnt_q <= 4'h0;
          if (rw_q) begin
            sda_oe_o <= ~rd_now[7];
            shift_q <= {rd_now[6:0], 1'b0};
            state_q <= rgb_pkg::ST_RDATA;
          end else begin
            sda_oe_o <= 1'b0;
            state_q <= rgb_pkg::ST_REG;
          end
        end
        rgb_pkg::ST_REG: begin
          if (bitcnt_q == 4'h8) begin
            ptr_q <= shift_q;
            sda_oe_o <= 1'b1;
            state_q <= rgb_pkg::ST_RACK;
          end
        end
        rgb_pkg::ST_WDATA: begin
          if (bitcnt_q == 4'h8) begin
            sda_oe_o <= 1'b1;
            state_q <= rgb_pkg::ST_WACK;
          end
        end
        rgb_pkg::ST_RACK, rgb_pkg::ST_WACK: begin
          if (state_q == rgb_pkg::ST_WACK) ptr_q <= ptr_q + 8'h01;
          sda_oe_o <= 1'b0;
          bitcnt_q <= 4'h0;
          state_q <= rgb_pkg::ST_WDATA;
        end
        rgb_pkg::ST_RDATA: begin
          if (bitcnt_q == 4'h8) begin
            sda_oe_o <= 1'b0;
            state_q <= rgb_pkg::ST_MACK;
          end else begin
            sda_oe_o <= ~shift_q[7];
            shift_q <= {shift_q[6:0], 1'b0};
          end
        end
        rgb_pkg::ST_MACK: begin
          bitcnt_q <= 4'h0;
          if (nack_q) begin
            state_q <= rgb_pkg::ST_IDLE;
          end else begin
            ptr_q <= ptr_q + 8'h01;
            sda_oe_o <= ~rd_next[7];
            shift_q <= {rd_next[6:0], 1'b0};
            state_q <= rgb_pkg::ST_RDATA;
          end
        end
        default: state_q <= rgb_pkg::ST_IDLE;
      endcase
    end
  end

  // Open-drain: only ever pulls low
  assign sda_o = 1'b0;

  // PWM timebase
  rgb_pkg::rgb_tb_type tb_q;
  logic [1:0] div_q;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= 2'h0;
      tb_q <= '0;
    end else if (clr) begin
      div_q <= 2'h0;
      tb_q <= '0;
    end else begin
      tb_q.step <= 1'b0;
      tb_q.wrap <= 1'b0;
      if (div_q == 2'(rgb_pkg::PWM_TICK_DIV - 1)) begin
        div_q <= 2'h0;
        tb_q.step <= 1'b1;
        tb_q.cnt <= tb_q.cnt + 9'h001;
        if (tb_q.cnt == 9'h1FF) begin
          tb_q.wrap <= 1'b1;
          tb_q.frame <= tb_q.frame + 3'h1;
        end
      end else begin
        div_q <= div_q + 2'h1;
      end
    end
  end

  // Intensity curve, applied to intensity only
  function automatic logic [7:0] log_curve(input logic [7:0] v);
    logic [12:0] t;
    t = 13'({1'b1, v[4:0]}) << v[7:5];
    if (v == 8'h00) log_curve = 8'h00;
    else if (v == 8'hFF) log_curve = 8'hFF;
    else log_curve = t[12:5];
  endfunction

  logic [11:0] lit;

  for (genvar g = 0; g < rgb_pkg::NUM_CH; g++) begin : g_ch
    logic [7:0] ieff;
    assign ieff = cfg_q.log_scale ?
                  log_curve(int_q[g / rgb_pkg::CH_PER_MOD]) :
                  int_q[g / rgb_pkg::CH_PER_MOD];
    rgb_pwm_channel u_ch (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .clr_i(clr),
      .tb_i(tb_q),
      .color_i(color_q[g]),
      .intensity_i(ieff),
      .dither_en_i(cfg_q.dither_en),
      .phase_i(2'((g / rgb_pkg::CH_PER_MOD) % 3)),
      .pwm_o(sink_channel_n_o[g]),
      .lit_o(lit[g])
    );
  end

  // Idle deglitch and power save
  logic [IW-1:0] idle_q;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_q <= '0;
      power_save_o <= 1'b0;
    end else if (clr || !cfg_q.auto_sleep || (|lit) || start_det) begin
      idle_q <= '0;
      power_save_o <= 1'b0;
    end else if (idle_q == IW'(IDLE_DEGLITCH_CYC - 1)) begin
      power_save_o <= 1'b1;
    end else begin
      idle_q <= idle_q + IW'(1);
    end
  end

endmodule

// ---- test/rgb_i2c_host.sv ----
// Bus controller model for the serial register port.
module rgb_i2c_host (
  // Clock
  input wire logic clk_i,
  // Bus lines
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic w(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Data falls while the clock is high
  task automatic start();
    sda_low_o = 1'b0;
    w(2);
    scl_o = 1'b1;
    w(2);
    sda_low_o = 1'b1;
    w(2);
    scl_o = 1'b0;
    w(2);
  endtask

  task automatic stop();
    sda_low_o = 1'b1;
    w(2);
    scl_o = 1'b1;
    w(2);
    sda_low_o = 1'b0;
    w(4);
  endtask

  // Line read back at the end of the high phase
  task automatic bitx(input logic b, output logic r);
    sda_low_o = !b;
    w(2);
    scl_o = 1'b1;
    w(4);
    r = sda_i;
    scl_o = 1'b0;
    w(2);
  endtask

  task automatic xfer(input logic [7:0] d, input logic a,
    output logic [7:0] q, output logic na);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(a, na);
  endtask

  task automatic wr(input logic [6:0] ad, input logic [7:0] r,
    input logic [7:0] d, output logic nk);
    logic [7:0] q;
    logic n0, n1, n2;
    start();
    xfer({ad, 1'b0}, 1'b1, q, n0);
    xfer(r, 1'b1, q, n1);
    xfer(d, 1'b1, q, n2);
    stop();
    nk = n0 | n1 | n2;
  endtask

  task automatic rd(input logic [6:0] ad, input logic [7:0] r,
    output logic [7:0] d, output logic nk);
    logic [7:0] q;
    logic n0, n1, n2, n3;
    start();
    xfer({ad, 1'b0}, 1'b1, q, n0);
    xfer(r, 1'b1, q, n1);
    start();
    xfer({ad, 1'b1}, 1'b1, q, n2);
    xfer(8'hFF, 1'b1, d, n3);
    stop();
    nk = n0 | n1 | n2;
  endtask
endmodule

// ---- test/rgb_pwm_core_monitor.sv ----
// Pin-level checks of the RGB dimming core.
module rgb_pwm_core_monitor #(
  parameter int IDLE_DEGLITCH_CYC = rgb_pkg::IDLE_DEGLITCH_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Pins
  input wire logic en_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic [11:0] sink_channel_n_o,
  input wire logic power_save_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  int idle_q;

  // Cycles since the last START or disable
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_q <= 0;
    end else if (!en_i || (scl_i && $fell(sda_i))) begin
      idle_q <= 0;
    end else if (idle_q < IDLE_DEGLITCH_CYC) begin
      idle_q <= idle_q + 1;
    end
  end

  a_sda_drive_low: assert property (sda_o == 1'b0)
    else $error("sda_o not low");
  a_en_clear_pins: assert property (
    !en_i [*3] |=> !sink_channel_n_o && !sda_oe_o && !power_save_o)
    else $error("enable low did not clear");
  a_sink_on_step: assert property (disable iff (rst_i || !en_i)
    !$stable(sink_channel_n_o) |=> $stable(sink_channel_n_o) [*2])
    else $error("sink changed off step");
  a_ack_rise_low: assert property (
    $rose(sda_oe_o) |-> !scl_i && !$past(scl_i, 2))
    else $error("drive began early");
  a_ack_fall_low: assert property (disable iff (rst_i || !en_i)
    $fell(sda_oe_o) |-> !scl_i)
    else $error("drive ended while clock high");
  a_save_dark: assert property (
    power_save_o |-> sink_channel_n_o == 12'h000)
    else $error("power save while lit");
  a_save_delay: assert property (
    $rose(power_save_o) |-> idle_q >= IDLE_DEGLITCH_CYC)
    else $error("power save too early");
  a_save_wake: assert property (
    power_save_o && scl_i && $fell(sda_i) |-> ##[1:8] !power_save_o)
    else $error("start did not wake");

  c_save: cover property ($rose(power_save_o));
  c_ack: cover property ($rose(sda_oe_o));
  c_sink: cover property ($rose(sink_channel_n_o[3]));
endmodule

bind rgb_pwm_core rgb_pwm_core_monitor #(
  .IDLE_DEGLITCH_CYC(IDLE_DEGLITCH_CYC)
) u_rgb_pwm_core_monitor (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .en_i(en_i),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .sda_o(sda_o),
  .sda_oe_o(sda_oe_o),
  .sink_channel_n_o(sink_channel_n_o),
  .power_save_o(power_save_o)
);

// ---- test/test_rgb_pwm_color_intensity.sv ----
// Self-checking bench of the RGB dimming core.
module test_rgb_pwm_color_intensity;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int IDLE = 600;
  localparam int PER = 1536;
  logic clk, rst, en, scl, h_low, oe, sda_lo, ps, nk;
  logic [1:0] pins;
  logic [11:0] sink;
  logic [6:0] addr;
  logic [7:0] q;
  int failures, n_tests;
  int cnt[12];
  // Open-drain line with pull-up
  wire sda = !(h_low || oe);

  rgb_pwm_core #(.IDLE_DEGLITCH_CYC(IDLE)) u_rgb_pwm_core (
    .sys_clk_i(clk), .rst_i(rst), .en_i(en), .bus_select_pins_i(pins),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_lo), .sda_oe_o(oe),
    .sink_channel_n_o(sink), .power_save_o(ps));
  rgb_i2c_host u_rgb_i2c_host (.clk_i(clk), .sda_i(sda), .scl_o(scl),
    .sda_low_o(h_low));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wait_sink(input int i, input logic v);
    int k;
    for (k = 0; k < 3000 && sink[i] !== v; k++) cyc(1);
    if (k == 3000) begin
      failures++;
      final_report();
    end
  endtask

  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    u_rgb_i2c_host.wr(addr, r, d, nk);
    chk(16'(nk), 16'h0000);
  endtask

  task automatic rd(input logic [7:0] r);
    u_rgb_i2c_host.rd(addr, r, q, nk);
    chk(16'(nk), 16'h0000);
  endtask

  // High cycles of each sink over eight periods
  task automatic measure();
    cyc(2 * PER);
    cnt = '{default: 0};
    repeat (8 * PER) begin
      cyc(1);
      for (int i = 0; i < 12; i++) cnt[i] += int'(sink[i]);
    end
  endtask

  task automatic t_regs();
    rd(rgb_pkg::REG_CFG);
    chk(16'(q), 16'h0007);
    rd(rgb_pkg::REG_INT_BASE);
    chk(16'(q), 16'h00FF);
    rd(rgb_pkg::REG_INT_LAST);
    chk(16'(q), 16'h00FF);
    rd(rgb_pkg::REG_COLOR_LAST);
    chk(16'(q), 16'h0000);
    rd(8'h20);
    chk(16'(q), 16'h0000);
    $display("t_regs done");
  endtask

  task automatic t_save();
    cyc(IDLE + 20);
    chk(16'(ps), 16'h0001);
    rd(rgb_pkg::REG_STATUS);
    chk(16'(ps), 16'h0000);
    cyc(IDLE - 200);
    chk(16'(ps), 16'h0000);
    cyc(300);
    chk(16'(ps), 16'h0001);
    wr(rgb_pkg::REG_CFG, 8'h03);
    cyc(IDLE + 20);
    chk(16'(ps), 16'h0000);
    wr(rgb_pkg::REG_CFG, 8'h07);
    $display("t_save done");
  endtask

  task automatic t_addr();
    for (int p = 0; p < 4; p++) begin
      pins = 2'(p);
      cyc(4);
      u_rgb_i2c_host.wr({rgb_pkg::BUS_ADDR_HI, ~pins}, 8'h02, 8'hFF, nk);
      chk(16'(nk), 16'h0001);
      addr = {rgb_pkg::BUS_ADDR_HI, pins};
      wr(8'h02, 8'hFF);
    end
    $display("t_addr done");
  endtask

  task automatic t_levels();
    wr(8'h06, 8'hFF);
    wr(8'h09, 8'hFF);
    wr(8'h0A, 8'h20);
    wr(8'h03, 8'h20);
    measure();
    chk(16'(cnt[0]), 16'(4080 * 3));
    chk(16'(cnt[3]), 16'(47 * 3));
    chk(16'(cnt[4]), 16'(6 * 3));
    chk(16'(cnt[1]), 16'h0000);
    wr(rgb_pkg::REG_CFG, 8'h06);
    measure();
    chk(16'(cnt[3]), 16'(525 * 3));
    wr(rgb_pkg::REG_CFG, 8'h04);
    measure();
    chk(16'(cnt[3]), 16'(520 * 3));
    chk(16'(cnt[0]), 16'(4080 * 3));
    $display("t_levels done");
  endtask

  task automatic t_phase();
    int k, r1, r2;
    // One channel of each of modules 0, 1 and 2, all at full intensity
    wr(8'h03, 8'hFF);
    wr(8'h06, 8'h10);
    wr(8'h09, 8'h10);
    wr(8'h0C, 8'h10);
    cyc(2 * PER);
    wait_sink(0, 1'b0);
    wait_sink(0, 1'b1);
    r1 = 0;
    r2 = 0;
    for (k = 1; k <= 1500; k++) begin
      cyc(1);
      if (sink[3] === 1'b1 && r1 == 0) r1 = k;
      if (sink[6] === 1'b1 && r2 == 0) r2 = k;
    end
    chk(16'(r1), 16'(720));
    chk(16'(r2), 16'(1440));
    $display("t_phase done");
  endtask

  task automatic t_enable();
    en = 1'b0;
    cyc(150);
    chk(16'(sink), 16'h0000);
    chk(16'(oe), 16'h0000);
    chk(16'(sda_lo), 16'h0000);
    en = 1'b1;
    cyc(5);
    rd(8'h09);
    chk(16'(q), 16'h0000);
    $display("t_enable done");
  endtask

  initial begin
    failures = 0;
    n_tests = 0;
    rst = 1'b1;
    en = 1'b1;
    pins = 2'b00;
    addr = {rgb_pkg::BUS_ADDR_HI, 2'b00};
    cyc(10);
    rst = 1'b0;
    cyc(5);
    t_regs();
    t_save();
    t_addr();
    t_levels();
    t_phase();
    t_enable();
    final_report();
  end
endmodule
